// File: core/pllps_shifter.v
`timescale 1ns/1ps
`include "pllps_regs.vh"

// Serial input shift register with load strobe
module pllps_shifter (
  input wire clk_in, // System clock
  input wire nrst_in, // Async reset, active low
  input wire sclk_rise_in, // Serial clock rising edge pulse
  input wire sdata_in, // Synchronised serial data
  input wire load_rise_in, // Load enable rising edge pulse
  output reg [`PLLPS_SR_W-1:0] word_out, // Last loaded word
  output reg word_valid_out // One cycle pulse per load
);
  reg [`PLLPS_SR_W-1:0] shift;

  // One bit per serial clock rising edge, MSB first
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      shift <= {`PLLPS_SR_W{1'b0}};
      word_out <= {`PLLPS_SR_W{1'b0}};
      word_valid_out <= 1'b0;
    end else begin
      word_valid_out <= load_rise_in;
      if (sclk_rise_in) begin
        shift <= {shift[`PLLPS_SR_W-2:0], sdata_in}; // R1
      end
      if (load_rise_in) begin
        word_out <= shift;
      end
    end
  end
endmodule

// File: core/pllps_sync.v
`timescale 1ns/1ps
`include "pllps_regs.vh"

// Two flop synchroniser with rising edge detect on the synced level
module pllps_sync #(
  parameter W = 1
) (
  input wire clk_in, // System clock
  input wire nrst_in, // Async reset, active low
  input wire [W-1:0] raw_in, // Asynchronous pins
  output wire [W-1:0] level_out, // Synchronised level
  output wire [W-1:0] rise_out // One cycle pulse on rising edge
);
  reg [W-1:0] meta;
  reg [W-1:0] sync;
  reg [W-1:0] last;

  // Flop chain; meta is read by sync only
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      meta <= {W{1'b0}};
      sync <= {W{1'b0}};
      last <= {W{1'b0}};
    end else begin
      meta <= raw_in;
      sync <= meta;
      last <= sync;
    end
  end

  assign level_out = sync;
  assign rise_out = sync & ~last;
endmodule

// File: core/pllps_top.v
`timescale 1ns/1ps
`include "pllps_regs.vh"

// How it works
// [R1] Serial clock rising edge shifts one bit
// [R2] Phase error two or more drops lock
// [R3] Three good comparisons in a row raise lock
// [R4] Minimum overlap pulses remove detector dead zone
// [R5] Unlock pulses: high 8, low 16 periods
// [R6] Low wake pin puts section to sleep
// [R7] Serial words stored even while sleeping
// [R8] Sleeping section floats output, reports locked
// [R9] Wake restarts dividers, caps early error pulses
// [R10] Counters gated per section, buffer by either
// [R11] Host holds pins low at power on
module pllps_top (
  input wire clk_in, // 40 MHz system clock
  input wire nrst_in, // Async reset, active low
  input wire reference_osc_in, // Reference oscillator pin
  input wire fb_if_in, // IF prescaled feedback pin
  input wire fb_rf_in, // RF prescaled feedback pin
  input wire serial_clk_in, // Serial clock pin
  input wire serial_data_in, // Serial data pin
  input wire serial_load_in, // Word load enable pin
  input wire if_section_wake_n, // IF power save, low sleeps
  input wire rf_section_wake_n, // RF power save, low sleeps
  output wire phase_error_if_out, // IF detector drive level
  output wire phase_error_if_oe_n_out, // IF drive enable, low drives
  output wire phase_error_rf_out, // RF detector drive level
  output wire phase_error_rf_oe_n_out, // RF drive enable, low drives
  output reg lock_indicator_out, // Lock indication or test output
  output reg if_counters_on_out, // IF counters running
  output reg rf_counters_on_out, // RF counters running
  output reg osc_buffer_on_out // Reference buffer running
);
  wire [5:0] pin_lvl;
  wire [5:0] pin_rise;
  wire [1:0] wake_lvl;
  wire [1:0] wake_rise;
  wire [`PLLPS_SR_W-1:0] word;
  wire word_valid;
  wire osc_on;
  wire osc_tick;
  wire [1:0] lk;
  wire [1:0] pe_lvl;
  wire [1:0] pe_oen;
  wire fr_if;
  reg [`PLLPS_R_W-1:0] ref_div [0:1];
  reg [`PLLPS_N_W-1:0] n_div [0:1];
  reg [`PLLPS_A_W-1:0] a_div [0:1];
  reg [1:0] fc;
  reg [1:0] psw;
  reg lds;
  reg [4:0] ulk_cnt;
  reg ulk_high;

  // Pins from outside the clock domain
  pllps_sync #(.W(6)) u_pins (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .raw_in({serial_load_in, serial_data_in, serial_clk_in,
             fb_rf_in, fb_if_in, reference_osc_in}),
    .level_out(pin_lvl),
    .rise_out(pin_rise)
  );

  pllps_sync #(.W(2)) u_wake (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .raw_in({rf_section_wake_n, if_section_wake_n}),
    .level_out(wake_lvl),
    .rise_out(wake_rise)
  );

  // Serial shifter always runs, sleep or not
  pllps_shifter u_shift (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .sclk_rise_in(pin_rise[3]),
    .sdata_in(pin_lvl[4]),
    .load_rise_in(pin_rise[5]),
    .word_out(word),
    .word_valid_out(word_valid)
  );

  // Reference buffer on while either section awake
  assign osc_on = wake_lvl[0] | wake_lvl[1]; // R10
  assign osc_tick = pin_rise[0] & osc_on; // R10

  // Setting words latched regardless of sleep state
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ref_div[0] <= `PLLPS_R_RST;
      ref_div[1] <= `PLLPS_R_RST;
      n_div[0] <= `PLLPS_N_RST;
      n_div[1] <= `PLLPS_N_RST;
      a_div[0] <= `PLLPS_A_RST;
      a_div[1] <= `PLLPS_A_RST;
      fc <= 2'h3;
      psw <= 2'h0;
      lds <= 1'b0;
    end else if (word_valid) begin // R7
      case (word[`PLLPS_CNT_LSB+`PLLPS_CNT_W-1:`PLLPS_CNT_LSB])
        `PLLPS_CNT_REF_IF: begin
          ref_div[0] <= word[`PLLPS_R_LSB+`PLLPS_R_W-1:`PLLPS_R_LSB];
        end
        `PLLPS_CNT_REF_RF: begin
          ref_div[1] <= word[`PLLPS_R_LSB+`PLLPS_R_W-1:`PLLPS_R_LSB];
        end
        `PLLPS_CNT_N_IF: begin
          n_div[0] <= word[`PLLPS_N_LSB+`PLLPS_N_W-1:`PLLPS_N_LSB];
          a_div[0] <= word[`PLLPS_A_LSB+`PLLPS_A_W-1:`PLLPS_A_LSB];
          fc[0] <= word[`PLLPS_FC_BIT];
          psw[0] <= word[`PLLPS_SW_BIT];
          lds <= word[`PLLPS_LDS_BIT];
        end
        default: begin
          n_div[1] <= word[`PLLPS_N_LSB+`PLLPS_N_W-1:`PLLPS_N_LSB];
          a_div[1] <= word[`PLLPS_A_LSB+`PLLPS_A_W-1:`PLLPS_A_LSB];
          fc[1] <= word[`PLLPS_FC_BIT];
          psw[1] <= word[`PLLPS_SW_BIT];
        end
      endcase
    end
  end

  genvar s;
  generate
    for (s = 0; s < 2; s = s + 1) begin : sec
      wire run;
      wire t_ref;
      wire t_fb;
      wire cmp;
      wire up_win;
      wire lim_hit;
      reg [`PLLPS_R_W-1:0] rcnt;
      reg [`PLLPS_N_W-1:0] ncnt;
      reg fr;
      reg fp;
      reg up;
      reg dn;
      reg lead;
      reg [1:0] hold;
      reg [4:0] err;
      reg [1:0] good;
      reg locked;
      reg [2:0] wcmp;
      reg [4:0] dcnt;
      reg pe;
      reg pe_oe_n;

      assign run = wake_lvl[s]; // R6
      assign t_ref = osc_tick & run; // R10
      assign t_fb = pin_rise[1+s] & run; // R10

      // Reference and feedback dividers, restarted together on wake
      always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
          rcnt <= {`PLLPS_R_W{1'b0}};
          ncnt <= {`PLLPS_N_W{1'b0}};
          fr <= 1'b0;
          fp <= 1'b0;
        end else if (!run || wake_rise[s]) begin // R9
          rcnt <= {`PLLPS_R_W{1'b0}};
          ncnt <= {`PLLPS_N_W{1'b0}};
          fr <= 1'b0;
          fp <= 1'b0;
        end else begin
          fr <= 1'b0;
          fp <= 1'b0;
          if (t_ref) begin
            if (rcnt >= ref_div[s] - 1'b1) begin
              rcnt <= {`PLLPS_R_W{1'b0}};
              fr <= 1'b1;
            end else begin
              rcnt <= rcnt + 1'b1;
            end
          end
          if (t_fb) begin
            if (ncnt >= n_div[s] - 1'b1) begin
              ncnt <= {`PLLPS_N_W{1'b0}};
              fp <= 1'b1;
            end else begin
              ncnt <= ncnt + 1'b1;
            end
          end
        end
      end

      // Comparison completes when both edges have been seen
      assign cmp = (up | fr) & (dn | fp) & ~(up & dn);

      // Phase frequency detector with forced overlap
      always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
          up <= 1'b0;
          dn <= 1'b0;
          lead <= 1'b1;
          hold <= 2'h0;
          err <= 5'h00;
        end else if (!run) begin
          up <= 1'b0;
          dn <= 1'b0;
          hold <= 2'h0;
          err <= 5'h00;
        end else if (up && dn) begin
          // Both sides stay on a minimum time
          if (hold == `PLLPS_DZ_CYC - 1'b1) begin // R4
            up <= 1'b0;
            dn <= 1'b0;
            hold <= 2'h0;
            err <= 5'h00;
          end else begin
            hold <= hold + 1'b1;
          end
        end else begin
          if (fr) begin
            up <= 1'b1;
          end
          if (fp) begin
            dn <= 1'b1;
          end
          if (!up && !dn && (fr || fp)) begin
            lead <= fr;
          end
          if ((up ^ dn) && t_ref && err != `PLLPS_ERR_MAX) begin
            err <= err + 1'b1;
          end
        end
      end

      // Lock detect over consecutive comparisons
      always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
          good <= `PLLPS_LOCK_CMP;
          locked <= 1'b1;
        end else if (!run) begin
          good <= `PLLPS_LOCK_CMP; // R8
          locked <= 1'b1; // R8
        end else if (cmp) begin
          if (err >= `PLLPS_ERR_UNLOCK) begin
            good <= 2'h0;
            locked <= 1'b0; // R2
          end else if (good >= `PLLPS_LOCK_CMP - 1'b1) begin
            good <= `PLLPS_LOCK_CMP;
            locked <= 1'b1; // R3
          end else begin
            good <= good + 1'b1;
          end
        end
      end

      // Early comparisons after wake have capped drive
      assign lim_hit = (wcmp != `PLLPS_WAKE_CMP) && (dcnt >= `PLLPS_LIM_CYC);
      assign up_win = lead;

      always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
          wcmp <= 3'h0;
          dcnt <= 5'h00;
        end else if (!run || wake_rise[s]) begin
          wcmp <= 3'h0; // R9
          dcnt <= 5'h00;
        end else begin
          if (cmp && wcmp != `PLLPS_WAKE_CMP) begin
            wcmp <= wcmp + 1'b1;
          end
          if (!(up | dn)) begin
            dcnt <= 5'h00;
          end else if (!lim_hit) begin
            dcnt <= dcnt + 1'b1;
          end
        end
      end

      // Registered drive; float when idle, asleep or capped
      always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
          pe <= 1'b0;
          pe_oe_n <= 1'b1;
        end else begin
          pe <= up_win ? fc[s] : ~fc[s];
          pe_oe_n <= ~(run & (up | dn) & ~lim_hit); // R8 R9
        end
      end

      assign lk[s] = locked;
      assign pe_lvl[s] = pe;
      assign pe_oen[s] = pe_oe_n;
    end
  endgenerate

  assign phase_error_if_out = pe_lvl[0];
  assign phase_error_if_oe_n_out = pe_oen[0];
  assign phase_error_rf_out = pe_lvl[1];
  assign phase_error_rf_oe_n_out = pe_oen[1];
  assign fr_if = sec[0].fr;

  // Unlock pulse train timed by reference periods
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ulk_cnt <= 5'h00;
      ulk_high <= 1'b0;
    end else if (lk[0] && lk[1]) begin
      ulk_cnt <= 5'h00;
      ulk_high <= 1'b0;
    end else if (osc_tick) begin
      if (!ulk_high && ulk_cnt >= `PLLPS_UNLK_LOW - 1'b1) begin // R5
        ulk_cnt <= 5'h00;
        ulk_high <= 1'b1;
      end else if (ulk_high && ulk_cnt >= `PLLPS_UNLK_HIGH - 1'b1) begin // R5
        ulk_cnt <= 5'h00;
        ulk_high <= 1'b0;
      end else begin
        ulk_cnt <= ulk_cnt + 1'b1;
      end
    end
  end

  // Lock output and power state outputs
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      lock_indicator_out <= 1'b1;
      if_counters_on_out <= 1'b0;
      rf_counters_on_out <= 1'b0;
      osc_buffer_on_out <= 1'b0;
    end else begin
      if (lds) begin
        lock_indicator_out <= fr_if;
      end else begin
        lock_indicator_out <= (lk[0] & lk[1]) | ulk_high; // R2 R3 R5
      end
      if_counters_on_out <= wake_lvl[0]; // R10
      rf_counters_on_out <= wake_lvl[1]; // R10
      osc_buffer_on_out <= osc_on; // R10
    end
  end
endmodule

// File: shared/pllps_regs.vh
`ifndef PLLPS_REGS_VH
`define PLLPS_REGS_VH

// Serial word layout, last bit shifted sits at bit 0
`define PLLPS_SR_W 23
`define PLLPS_CNT_LSB 0
`define PLLPS_CNT_W 2
`define PLLPS_R_LSB 2
`define PLLPS_R_W 14
`define PLLPS_LDS_BIT 2
`define PLLPS_SW_BIT 3
`define PLLPS_FC_BIT 4
`define PLLPS_A_LSB 5
`define PLLPS_A_W 7
`define PLLPS_N_LSB 12
`define PLLPS_N_W 11

// Control codes selecting the target of a word
`define PLLPS_CNT_REF_IF 2'h0
`define PLLPS_CNT_REF_RF 2'h1
`define PLLPS_CNT_N_IF 2'h2
`define PLLPS_CNT_N_RF 2'h3

// Reset values
`define PLLPS_R_RST 14'h0005
`define PLLPS_N_RST 11'h005
`define PLLPS_A_RST 7'h00

// Lock detect, in reference oscillator periods and comparisons
`define PLLPS_ERR_UNLOCK 5'h02
`define PLLPS_ERR_MAX 5'h1f
`define PLLPS_LOCK_CMP 2'h3
`define PLLPS_UNLK_HIGH 5'h08
`define PLLPS_UNLK_LOW 5'h10

// Anti dead zone overlap and wake limiting, in clk_in cycles and comparisons
`define PLLPS_DZ_CYC 2'h2
`define PLLPS_WAKE_CMP 3'h4
`define PLLPS_LIM_CYC 5'h08

`endif

// File: test/pll_lock_detect_power_save_tb_top.sv
`timescale 1ns/1ps
`include "pllps_regs.vh"
module pll_lock_detect_power_save_tb_top;
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic ref_osc = 1'b0;
  logic fb = 1'b0;
  realtime fb_half = 100.0;
  wire sclk, sdata, sload, wake_if_n, wake_rf_n;
  wire pe_if, oe_if_n, pe_rf, oe_rf_n, lock, if_on, rf_on, buf_on;
  int num_errors = 0;
  int n_compared = 0;
  int cycles = 0;
  int n, lows, run, maxrun, tog, pe_hi;
  // Clocks: system, reference, feedback
  always #12.5 clk_in = ~clk_in;
  always #100 ref_osc = ~ref_osc;
  always #(fb_half) fb = ~fb;
  pllps_host host (.clk_in(clk_in), .serial_clk_out(sclk), .serial_data_out(sdata),
    .serial_load_out(sload), .if_wake_n_out(wake_if_n), .rf_wake_n_out(wake_rf_n));
  pllps_top dut (.clk_in(clk_in), .nrst_in(nrst_in), .reference_osc_in(ref_osc),
    .fb_if_in(fb), .fb_rf_in(fb), .serial_clk_in(sclk), .serial_data_in(sdata),
    .serial_load_in(sload), .if_section_wake_n(wake_if_n), .rf_section_wake_n(wake_rf_n),
    .phase_error_if_out(pe_if), .phase_error_if_oe_n_out(oe_if_n),
    .phase_error_rf_out(pe_rf), .phase_error_rf_oe_n_out(oe_rf_n),
    .lock_indicator_out(lock), .if_counters_on_out(if_on), .rf_counters_on_out(rf_on),
    .osc_buffer_on_out(buf_on));
  task automatic print_verdict();
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input logic ok, input string msg);
    n_compared++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("mismatch %0t %s", $time, msg);
    end
  endtask
  // Drive pulse runs on IF and lock toggles over a window
  task automatic watch(input int cyc);
    logic last;
    lows = 0;
    run = 0;
    maxrun = 0;
    tog = 0;
    pe_hi = 0;
    last = lock;
    repeat (cyc) begin
      @(posedge clk_in);
      #1;
      run = (oe_if_n === 1'b0) ? run + 1 : 0;
      lows += (run > 0);
      if (run > maxrun) maxrun = run;
      // Past the overlap, a lagging reference must drive low with polarity bit set
      pe_hi += (run > 2 && pe_if !== 1'b0);
      tog += (lock !== last);
      last = lock;
    end
  endtask
  task automatic wait_lock(input logic v);
    n = 0;
    while (lock !== v && n < 2000) begin
      @(posedge clk_in);
      #1;
      n++;
    end
  endtask
  function automatic logic [22:0] n_word(input logic lds);
    return {11'h005, 7'h00, 1'b1, 1'b0, lds, `PLLPS_CNT_N_IF};
  endfunction
  // Hang guard
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 30000) begin
      num_errors++;
      $display("mismatch %0t timeout", $time);
      print_verdict();
    end
  end
  // Main sequence
  initial begin
    repeat (10) @(posedge clk_in);
    #1 nrst_in = 1'b1;
    repeat (40) @(posedge clk_in);
    host.send_word(n_word(1'b1));
    host.send_word({7'h00, 14'h0005, `PLLPS_CNT_REF_IF});
    host.set_wake(1'b1, 1'b0);
    watch(200);
    chk(tog >= 2, "test output idle");
    host.send_word(n_word(1'b0));
    repeat (600) @(posedge clk_in);
    watch(200);
    chk(lock === 1'b1 && tog == 0, "no lock");
    chk(lows > 0, "no pulses at lock");
    fb_half = 75.0;
    wait_lock(1'b0);
    chk(n < 2000, "lock kept");
    wait_lock(1'b1);
    chk(n <= 128, "low too long");
    wait_lock(1'b0);
    chk(n >= 64, "high too short");
    host.set_wake(1'b0, 1'b0);
    repeat (10) @(posedge clk_in);
    host.set_wake(1'b1, 1'b0);
    watch(160);
    chk(maxrun <= `PLLPS_LIM_CYC + `PLLPS_DZ_CYC, "wake not capped");
    watch(400);
    chk(maxrun > `PLLPS_LIM_CYC + `PLLPS_DZ_CYC, "cap stays");
    chk(pe_hi == 0, "IF drive level");
    for (int k = 0; k < 4; k++) begin
      host.set_wake(k[0], k[1]);
      repeat (10) @(posedge clk_in);
      #1;
      chk(if_on === k[0] && rf_on === k[1] && buf_on === (k[0] | k[1]), "gating");
      if (k == 0) chk(lock === 1'b1 && oe_if_n === 1'b1 && oe_rf_n === 1'b1, "sleep");
      // RF alone awake: feedback leads after restart, so first drive is low
      if (k == 2) begin
        n = 0;
        while (oe_rf_n !== 1'b0 && n < 200) begin
          @(posedge clk_in);
          #1;
          n++;
        end
        chk(n < 200 && pe_rf === 1'b0, "RF drive level");
      end
    end
    print_verdict();
  end
endmodule

// File: test/pllps_checker.sv
`timescale 1ns/1ps
// Gating, float and buffer relations seen at the top ports
module pllps_checker (
  input wire clk_in, // Clock
  input wire nrst_in, // Reset, active low
  input wire if_section_wake_n, // IF power save pin
  input wire rf_section_wake_n, // RF power save pin
  input wire phase_error_if_oe_n_out, // IF drive enable
  input wire phase_error_rf_oe_n_out, // RF drive enable
  input wire if_counters_on_out, // IF counters
  input wire rf_counters_on_out, // RF counters
  input wire osc_buffer_on_out // Ref buffer
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  if_stop_a: assert property ($fell(if_section_wake_n) |-> ##[1:6] !if_counters_on_out)
    else $error("IF counters run in sleep");
  rf_stop_a: assert property ($fell(rf_section_wake_n) |-> ##[1:6] !rf_counters_on_out)
    else $error("RF counters run in sleep");
  if_run_a: assert property (if_section_wake_n [*6] |-> if_counters_on_out)
    else $error("IF counters stopped");
  rf_run_a: assert property (rf_section_wake_n [*6] |-> rf_counters_on_out)
    else $error("RF counters stopped");
  buf_on_a: assert property ((if_section_wake_n | rf_section_wake_n) [*6] |-> osc_buffer_on_out)
    else $error("buffer off while awake");
  buf_off_a: assert property (!(if_section_wake_n | rf_section_wake_n) [*6] |-> !osc_buffer_on_out)
    else $error("buffer on in full sleep");
  if_float_a: assert property (!if_section_wake_n [*6] |-> phase_error_if_oe_n_out)
    else $error("IF output driven in sleep");
  rf_float_a: assert property (!rf_section_wake_n [*6] |-> phase_error_rf_oe_n_out)
    else $error("RF output driven in sleep");
endmodule

bind pllps_top pllps_checker chk (.clk_in(clk_in), .nrst_in(nrst_in),
  .if_section_wake_n(if_section_wake_n), .rf_section_wake_n(rf_section_wake_n),
  .phase_error_if_oe_n_out(phase_error_if_oe_n_out),
  .phase_error_rf_oe_n_out(phase_error_rf_oe_n_out), .if_counters_on_out(if_counters_on_out),
  .rf_counters_on_out(rf_counters_on_out), .osc_buffer_on_out(osc_buffer_on_out));

// File: test/pllps_host.sv
`timescale 1ns/1ps
// Host side: serial words and power save pins
module pllps_host (
  input wire clk_in, // Pacing clock
  output reg serial_clk_out, // Serial clock, idles low
  output reg serial_data_out, // Serial data
  output reg serial_load_out, // Load enable
  output reg if_wake_n_out, // IF power save, low sleeps
  output reg rf_wake_n_out // RF power save, low sleeps
);
  // Sleep both sections from power on
  initial begin
    serial_clk_out = 1'b0;
    serial_data_out = 1'b0;
    serial_load_out = 1'b0;
    if_wake_n_out = 1'b0;
    rf_wake_n_out = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  // MSB first, data settled 4 cycles before each rise
  task automatic send_word(input logic [22:0] w);
    tick(1);
    for (int i = 22; i >= 0; i--) begin
      serial_data_out = w[i];
      tick(4);
      serial_clk_out = 1'b1;
      tick(4);
      serial_clk_out = 1'b0;
    end
    serial_data_out = ~w[0];
    tick(4);
    serial_load_out = 1'b1;
    tick(4);
    serial_load_out = 1'b0;
    tick(8);
  endtask
  task automatic set_wake(input logic if_lvl, input logic rf_lvl);
    tick(1);
    if_wake_n_out = if_lvl;
    rf_wake_n_out = rf_lvl;
  endtask
endmodule
